// >>> hw/scc_cfg.svh
// Purpose: constants of the system clock source control block
// Assumes: 20 MHz core clock, 32-bit classic Wishbone register port
// Notes:   offsets are byte addresses, registers hold up to 8 bits in the low lane
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// register byte offsets
`define SCC_ADR_CLK_MODE   6'h00
`define SCC_ADR_XTAL_CTRL  6'h04
`define SCC_ADR_FAST_TRIM  6'h08
`define SCC_ADR_MISC_CTRL  6'h0C
`define SCC_ADR_STATUS     6'h10
// field positions
`define SCC_BIT_XTAL_EN    7
`define SCC_BIT_FAST_EN    4
`define SCC_BIT_SLOW_EN    2
`define SCC_BIT_WDT_EN     0
`define SCC_BIT_PA5_OUT    1
// reset values
// slow RC undivided with the fast oscillator off, so an uncalibrated boot keeps it off
`define SCC_CLK_MODE_RST   8'hE6
`define SCC_XTAL_CTRL_RST  8'h00
`define SCC_FAST_TRIM_RST  8'h10
// boot-time clock modes per calibration option
`define SCC_MODE_DIV2      8'h34
`define SCC_MODE_DIV4      8'h14
`define SCC_MODE_DIV8      8'h3C
`define SCC_MODE_DIV16     8'h1C
`define SCC_MODE_DIV32     8'h7C
`define SCC_MODE_SLOW      8'hE4
`define SCC_CAL_DISABLE    3'h6
// timing
`define SCC_CLK_MHZ        20
`define SCC_BOOT_SLOW_US   50000
`define SCC_BOOT_FAST_US   750
`define SCC_SLOW_PERIOD    8'h28

`endif

// >>> hw/scc_pkg.sv
// Purpose: shared types of the clock source control block
// Assumes: constants live in scc_cfg.svh
// Notes:   none
package scc_pkg;
   // clock source as seen by the clock generator
   typedef enum logic [1:0] {
      SRC_FAST = 2'h0,
      SRC_SLOW = 2'h1,
      SRC_XTAL = 2'h2
   } scc_src_t;
   // boot sequencer states, one-hot
   typedef enum logic [2:0] {
      BOOT_HOLD  = 3'h1,
      BOOT_APPLY = 3'h2,
      BOOT_RUN   = 3'h4
   } scc_boot_t;
endpackage

// >>> hw/scc_clk_if.sv
// Purpose: carries source ticks and selection from control to generator
// Assumes: all signals on clk
// Notes:   req_div is the divide ratio as a power of two
`timescale 1ns/10ps
interface scc_clk_if;
   scc_pkg::scc_src_t req_src;    // requested source
   logic [2:0]        req_div;    // requested divide, log2
   logic              fast_tick;  // fast RC edge
   logic              slow_tick;  // slow RC edge
   logic              xtal_tick;  // crystal edge
   logic              sys_clk;    // generated system clock
   scc_pkg::scc_src_t act_src;    // source now in use
   modport ctl (output req_src, req_div, fast_tick, slow_tick, xtal_tick,
                input sys_clk, act_src);
   modport gen (input req_src, req_div, fast_tick, slow_tick, xtal_tick,
                output sys_clk, act_src);
endinterface

// >>> hw/scc_osc.sv
// Purpose: behavioural oscillator, one tick per output edge
// Assumes: period is in core clock cycles, zero treated as one
// Notes:   ticks stop at once when disabled
`timescale 1ns/10ps
module scc_osc #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         en,
   input  wire logic [W-1:0] period,
   output logic              tick
);
   logic [W-1:0] cnt_q; // cycles since last tick

   // count cycles of the period, emit a tick on wrap
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (!en) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (cnt_q + W'(1) >= period) begin
         cnt_q <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + W'(1);
         tick  <= 1'b0;
      end
   end
endmodule

// >>> hw/scc_clkgen.sv
// Purpose: glitch-free divided system clock from the selected source ticks
// Assumes: ticks are one-cycle pulses
// Notes:   selection changes only in a low phase, at its end or when the active source is dead
`timescale 1ns/10ps
module scc_clkgen (
   input  wire logic clk,
   input  wire logic arst_n,
   scc_clk_if.gen    cif
);
   logic [2:0] act_div_q; // divide in use, log2
   logic [6:0] cnt_q;     // ticks in the current phase
   logic [8:0] idle_q;    // cycles since the active source last ticked
   logic [6:0] phase_len; // ticks per phase
   logic       tick;      // tick of the active source
   logic       stuck;     // active source silent far longer than any period
   logic       change;    // requested selection differs from the active one

   always_comb begin
      phase_len = 7'h01 << act_div_q;
      case (cif.act_src)
         scc_pkg::SRC_SLOW: tick = cif.slow_tick;
         scc_pkg::SRC_XTAL: tick = cif.xtal_tick;
         default:           tick = cif.fast_tick;
      endcase
   end

   assign change = (cif.req_src != cif.act_src) || (cif.req_div != act_div_q);

   // a dead source must not hang a low clock forever; a live but slow one
   // must not be cut short, hence the long silence before giving up on it
   assign stuck = !cif.sys_clk && (idle_q == 9'h1FF)
                  && (cif.req_src != cif.act_src);

   // silence counter; saturates so a dead source stays flagged
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_q <= 9'h000;
      end else if (tick) begin
         idle_q <= 9'h000;
      end else if (idle_q != 9'h1FF) begin
         idle_q <= idle_q + 9'h001;
      end
   end

   // phases are whole; handover only when low is complete or dead
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q       <= 7'h00;
         cif.sys_clk <= 1'b0;
         cif.act_src <= scc_pkg::SRC_SLOW;
         act_div_q   <= 3'h0;
      end else if (tick && (cnt_q == phase_len - 7'h01)) begin
         cnt_q <= 7'h00;
         if (!cif.sys_clk && change) begin
            // low phase lengthens and restarts on the new selection, so a
            // source that never ticks keeps the clock low
            cif.act_src <= cif.req_src;
            act_div_q   <= cif.req_div;
         end else begin
            cif.sys_clk <= !cif.sys_clk;
         end
      end else if (tick) begin
         cnt_q <= cnt_q + 7'h01;
      end else if (stuck) begin
         // low phase only lengthens here, never shortens
         cnt_q       <= 7'h00;
         cif.act_src <= cif.req_src;
         act_div_q   <= cif.req_div;
      end
   end

   // a source or divide change never lands inside a high phase
   glitch_free_a : assert property (@(posedge clk) disable iff (!arst_n)
      ($changed(cif.act_src) || $changed(act_div_q)) |-> !$past(cif.sys_clk))
      else $error("clock selection changed during high phase");
endmodule

// >>> hw/scc_top.sv
// Purpose: system clock source control with boot sequencer and Wishbone registers
// Assumes: arst_n is the power-on reset; straps steady around its release
// Notes:   oscillators are modelled as tick generators on clk
`timescale 1ns/10ps
`include "scc_cfg.svh"
module scc_top #(
   parameter int BOOT_SLOW_CYC = `SCC_BOOT_SLOW_US * `SCC_CLK_MHZ,
   parameter int BOOT_FAST_CYC = `SCC_BOOT_FAST_US * `SCC_CLK_MHZ
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   // classic wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // straps and stored calibration
   input  wire logic        boot_fast,
   input  wire logic [2:0]  cal_option,
   input  wire logic [7:0]  cal_trim,
   // crystal input edge source
   input  wire logic        xtal_in,
   // clock and control outputs
   output logic             sys_clk_o,
   output logic             xtal_en_o,
   output logic [1:0]       xtal_drive_o,
   output logic             fast_en_o,
   output logic             slow_en_o,
   output logic [7:0]       fast_trim_o,
   output logic             wdt_en_o,
   output logic             port_a_bit_five_oe_n,
   output logic             cpu_run_o
);
   scc_clk_if cif ();

   logic [7:0]       clk_mode_q;  // system_clock_select register
   logic [7:0]       xtal_ctrl_q; // crystal enable and drive
   logic [7:0]       trim_q;      // fast RC trim
   logic [1:0]       misc_q;      // watchdog enable, pin output
   logic             cal_done_q;  // stored trim applied
   logic             xtal_prev_q; // crystal input last cycle
   scc_pkg::scc_boot_t state_q;   // boot sequencer
   logic [31:0]      boot_cnt_q;  // boot wait counter
   logic             strap_q;     // straps captured
   logic             fast_boot_q; // captured boot length
   logic [2:0]       opt_q;       // captured calibration option
   logic             bus_req;     // new bus cycle this clock
   logic             bus_wr;      // write commits this clock
   logic [31:0]      rd_data;     // read mux
   logic [31:0]      boot_len;    // selected boot length
   logic [7:0]       boot_mode;   // mode applied at boot end
   logic             running;     // boot finished

   assign running = (state_q == scc_pkg::BOOT_RUN);
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes commit on the edge where the master sees ack
   assign bus_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && running;
   assign boot_len = fast_boot_q ? 32'(BOOT_FAST_CYC) : 32'(BOOT_SLOW_CYC);

   // clock mode chosen by each calibrated option
   always_comb begin
      case (opt_q)
         3'h0:    boot_mode = `SCC_MODE_DIV2;
         3'h1:    boot_mode = `SCC_MODE_DIV4;
         3'h2:    boot_mode = `SCC_MODE_DIV8;
         3'h3:    boot_mode = `SCC_MODE_DIV16;
         3'h4:    boot_mode = `SCC_MODE_DIV32;
         3'h5:    boot_mode = `SCC_MODE_SLOW;
         default: boot_mode = clk_mode_q;
      endcase
   end

   // decode source and divide from the mode byte: {bit3, bits 7:5}
   always_comb begin
      case ({clk_mode_q[3], clk_mode_q[7:5]})
         4'h1: begin cif.req_src = scc_pkg::SRC_FAST; cif.req_div = 3'h1; end
         4'h0: begin cif.req_src = scc_pkg::SRC_FAST; cif.req_div = 3'h2; end
         4'h9: begin cif.req_src = scc_pkg::SRC_FAST; cif.req_div = 3'h3; end
         4'h8: begin cif.req_src = scc_pkg::SRC_FAST; cif.req_div = 3'h4; end
         4'hB: begin cif.req_src = scc_pkg::SRC_FAST; cif.req_div = 3'h5; end
         4'h7: begin cif.req_src = scc_pkg::SRC_SLOW; cif.req_div = 3'h0; end
         4'h5: begin cif.req_src = scc_pkg::SRC_XTAL; cif.req_div = 3'h0; end
         // remaining codes run the fast RC divided by 64
         default: begin cif.req_src = scc_pkg::SRC_FAST; cif.req_div = 3'h6; end
      endcase
   end

   // oscillators; the trim sets the fast period
   scc_osc #(.W(8)) u_fast (
      .clk    (clk),
      .arst_n (arst_n),
      .en     (fast_en_o),
      .period (trim_q),
      .tick   (cif.fast_tick)
   );
   scc_osc #(.W(8)) u_slow (
      .clk    (clk),
      .arst_n (arst_n),
      .en     (slow_en_o),
      .period (`SCC_SLOW_PERIOD),
      .tick   (cif.slow_tick)
   );

   // crystal edges count only while its enable is set
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         xtal_prev_q   <= 1'b0;
         cif.xtal_tick <= 1'b0;
      end else begin
         xtal_prev_q   <= xtal_in;
         cif.xtal_tick <= xtal_en_o && (xtal_in != xtal_prev_q);
      end
   end

   scc_clkgen u_gen (
      .clk    (clk),
      .arst_n (arst_n),
      .cif    (cif)
   );

   // boot sequencer: capture straps after release, wait, apply option
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q     <= scc_pkg::BOOT_HOLD;
         boot_cnt_q  <= 32'h0000_0000;
         strap_q     <= 1'b0;
         fast_boot_q <= 1'b0;
         opt_q       <= `SCC_CAL_DISABLE;
      end else begin
         case (state_q)
            scc_pkg::BOOT_HOLD: begin
               if (!strap_q) begin
                  strap_q     <= 1'b1;
                  fast_boot_q <= boot_fast;
                  opt_q       <= cal_option;
               end else if (boot_cnt_q + 32'h0000_0001 >= boot_len) begin
                  state_q <= scc_pkg::BOOT_APPLY;
               end else begin
                  boot_cnt_q <= boot_cnt_q + 32'h0000_0001;
               end
            end
            scc_pkg::BOOT_APPLY: state_q <= scc_pkg::BOOT_RUN;
            scc_pkg::BOOT_RUN:   state_q <= scc_pkg::BOOT_RUN;
            default:             state_q <= scc_pkg::BOOT_HOLD;
         endcase
      end
   end

   // clock mode register: boot option, then software writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_mode_q <= `SCC_CLK_MODE_RST;
      end else if (state_q == scc_pkg::BOOT_APPLY) begin
         clk_mode_q <= boot_mode;
      end else if (bus_wr && wb_adr_i == `SCC_ADR_CLK_MODE) begin
         clk_mode_q <= wb_dat_i[7:0];
      end
   end

   // crystal control: enable bit and drive field
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         xtal_ctrl_q <= `SCC_XTAL_CTRL_RST;
      end else if (bus_wr && wb_adr_i == `SCC_ADR_XTAL_CTRL) begin
         xtal_ctrl_q <= wb_dat_i[7:0];
      end
   end

   // trim: stored calibration loaded once per calibrated boot, never recomputed
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trim_q     <= `SCC_FAST_TRIM_RST;
         cal_done_q <= 1'b0;
      end else if (state_q == scc_pkg::BOOT_APPLY) begin
         if (opt_q < `SCC_CAL_DISABLE) begin
            trim_q     <= cal_trim;
            cal_done_q <= 1'b1;
         end
      end else if (bus_wr && wb_adr_i == `SCC_ADR_FAST_TRIM) begin
         trim_q <= wb_dat_i[7:0];
      end
   end

   // misc: watchdog enable and port pin direction
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         misc_q <= 2'h1;
      end else if (state_q == scc_pkg::BOOT_APPLY) begin
         misc_q <= {1'b0, opt_q >= `SCC_CAL_DISABLE};
      end else if (bus_wr && wb_adr_i == `SCC_ADR_MISC_CTRL) begin
         misc_q <= wb_dat_i[1:0];
      end
   end

   // registered outputs; both RC oscillators forced on until boot ends
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         xtal_en_o            <= 1'b0;
         xtal_drive_o         <= 2'h0;
         fast_en_o            <= 1'b1;
         slow_en_o            <= 1'b1;
         fast_trim_o          <= `SCC_FAST_TRIM_RST;
         wdt_en_o             <= 1'b1;
         port_a_bit_five_oe_n <= 1'b1;
         cpu_run_o            <= 1'b0;
         sys_clk_o            <= 1'b0;
      end else begin
         xtal_en_o            <= xtal_ctrl_q[`SCC_BIT_XTAL_EN];
         xtal_drive_o         <= xtal_ctrl_q[6:5];
         fast_en_o            <= clk_mode_q[`SCC_BIT_FAST_EN] || !running;
         slow_en_o            <= clk_mode_q[`SCC_BIT_SLOW_EN] || !running;
         fast_trim_o          <= trim_q;
         wdt_en_o             <= misc_q[`SCC_BIT_WDT_EN];
         port_a_bit_five_oe_n <= !misc_q[`SCC_BIT_PA5_OUT];
         cpu_run_o            <= running;
         sys_clk_o            <= cif.sys_clk;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr_i)
         `SCC_ADR_CLK_MODE:  rd_data[7:0] = clk_mode_q;
         `SCC_ADR_XTAL_CTRL: rd_data[7:0] = xtal_ctrl_q;
         `SCC_ADR_FAST_TRIM: rd_data[7:0] = trim_q;
         `SCC_ADR_MISC_CTRL: rd_data[1:0] = misc_q;
         `SCC_ADR_STATUS:    rd_data[5:0] = {cal_done_q, cif.sys_clk,
                                             cif.act_src, fast_boot_q, running};
         default:            rd_data = 32'h0000_0000;
      endcase
   end

   // bus answer: ack one cycle after the request, dropped the next
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   ack_single_a : assert property (@(posedge clk) disable iff (!arst_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   ack_cause_a : assert property (@(posedge clk) disable iff (!arst_n)
      $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");

   boot_hold_a : assert property (@(posedge clk) disable iff (!arst_n)
      (state_q == scc_pkg::BOOT_HOLD) |=> !cpu_run_o)
      else $error("cpu released during boot wait");

   boot_osc_on_a : assert property (@(posedge clk) disable iff (!arst_n)
      (state_q == scc_pkg::BOOT_APPLY) |=> fast_en_o && slow_en_o)
      else $error("rc oscillators not running at boot end");

   cal_mode_a : assert property (@(posedge clk) disable iff (!arst_n)
      (state_q == scc_pkg::BOOT_APPLY && opt_q == 3'h0) |=> clk_mode_q == 8'h34
      ##1 cif.req_div == 3'h1 && cif.req_src == scc_pkg::SRC_FAST)
      else $error("divide by two option not applied");

   cal_state_a : assert property (@(posedge clk) disable iff (!arst_n)
      (state_q == scc_pkg::BOOT_APPLY && opt_q < 3'h6) |=> ##1
      !wdt_en_o && slow_en_o && port_a_bit_five_oe_n && fast_trim_o == $past(cal_trim, 2))
      else $error("calibrated boot state wrong");

   no_cal_a : assert property (@(posedge clk) disable iff (!arst_n)
      (state_q == scc_pkg::BOOT_APPLY && opt_q >= 3'h6) |=>
      clk_mode_q == $past(clk_mode_q) ##1 wdt_en_o && !fast_en_o)
      else $error("uncalibrated boot state wrong");

   mode_write_a : assert property (@(posedge clk) disable iff (!arst_n)
      (bus_wr && wb_adr_i == 6'h00) |=> clk_mode_q == $past(wb_dat_i[7:0]))
      else $error("clock mode write not taken at once");

   slow_sel_a : assert property (@(posedge clk) disable iff (!arst_n)
      (clk_mode_q == 8'hE4) |-> cif.req_src == scc_pkg::SRC_SLOW && cif.req_div == 3'h0)
      else $error("slow mode decode wrong");

   drive_field_a : assert property (@(posedge clk) disable iff (!arst_n)
      running |=> xtal_drive_o == $past(xtal_ctrl_q[6:5]) && xtal_en_o == $past(xtal_ctrl_q[7]))
      else $error("crystal control not reflected");
endmodule

// >>> testbench/tb.sv
// Purpose: self-checking bench for the system clock source control block
// Assumes: shortened boot counts, classic wishbone single cycles
// Notes:   bus reads through rd are queued and compared by a monitor at ack
`timescale 1ns/10ps
`include "scc_cfg.svh"
module tb;
   localparam int SLOW_LEN = 20;   // shortened normal boot
   localparam int FAST_LEN = 10;   // shortened fast boot
   logic        clk = 1'b0, arst_n = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [5:0]  wb_adr_i = 6'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, sys_clk_o, xtal_en_o, fast_en_o, slow_en_o;
   logic        wdt_en_o, port_a_bit_five_oe_n, cpu_run_o;
   logic [1:0]  xtal_drive_o;
   logic [7:0]  fast_trim_o;
   logic        boot_fast = 1'b0, xtal_in = 1'b0;
   logic [2:0]  cal_option = 3'h0;
   logic [7:0]  cal_trim = 8'h10;
   logic [31:0] exp_q[$];          // expected read data, oldest first
   logic [31:0] rnd = 32'h0000_0005; // xorshift state
   int          error_cnt = 0, comparisons = 0, cyc_cnt = 0, rel_cnt, xt_cnt = 0;
   int          ph_len;            // cycles since last clock edge
   logic        ph_seen, last_clk;

   scc_top #(.BOOT_SLOW_CYC(SLOW_LEN), .BOOT_FAST_CYC(FAST_LEN)) dut_u (
      .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .boot_fast(boot_fast),
      .cal_option(cal_option), .cal_trim(cal_trim), .xtal_in(xtal_in),
      .sys_clk_o(sys_clk_o), .xtal_en_o(xtal_en_o), .xtal_drive_o(xtal_drive_o),
      .fast_en_o(fast_en_o), .slow_en_o(slow_en_o), .fast_trim_o(fast_trim_o),
      .wdt_en_o(wdt_en_o), .port_a_bit_five_oe_n(port_a_bit_five_oe_n),
      .cpu_run_o(cpu_run_o));

   // core clock, 50 ns period
   always #25 clk = ~clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // crystal waveform: one edge every 5 core cycles
   always @(posedge clk) begin
      xt_cnt <= (xt_cnt == 4) ? 0 : xt_cnt + 1;
      if (xt_cnt == 4) begin
         xtal_in <= ~xtal_in;
      end
   end

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 60000) begin
         error_cnt++;
         finish_test();
      end
   end

   // cycles from reset release until the core may run
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rel_cnt <= 0;
      end else if (cpu_run_o !== 1'b1) begin
         rel_cnt <= rel_cnt + 1;
      end
   end

   // read monitor: oldest note is compared when ack shows
   always @(posedge clk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         check("rd_data", wb_dat_o, exp_q.pop_front());
      end
   end

   // no clock phase may be shorter than the shortest legal half period
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_len <= 0;
         ph_seen <= 1'b0;
         last_clk <= 1'b0;
      end else begin
         last_clk <= sys_clk_o;
         ph_len <= ph_len + 1;
         if (sys_clk_o !== last_clk) begin
            ph_len <= 1;
            ph_seen <= 1'b1;
            if (ph_seen) check("phase_ok", 32'(ph_len >= 4), 32'h0000_0001);
         end
      end
   end

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [5:0] adr, input logic [7:0] dat,
                     input logic sel0, output logic [31:0] rd);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= {3'h7, sel0};
      wb_dat_i <= 32'(dat);
      // only the hang guard ends this wait
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] adr, input logic [7:0] dat, input logic sel0);
      logic [31:0] d;
      wb(1'b1, adr, dat, sel0, d);
   endtask

   task automatic rd(input logic [5:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      exp_q.push_back(exp);
      wb(1'b0, adr, 8'h00, 1'b1, d);
   endtask

   // power-on reset with straps, optional write during the boot wait
   task automatic boot(input logic [2:0] opt, input logic fast, input logic [7:0] tv,
                       input logic poke);
      int k;
      arst_n <= 1'b0;
      cal_option <= opt;
      boot_fast <= fast;
      cal_trim <= tv;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check("fast_en_boot", 32'(fast_en_o), 32'h0000_0001);
      check("slow_en_boot", 32'(slow_en_o), 32'h0000_0001);
      if (poke) wr(`SCC_ADR_CLK_MODE, 8'hE4, 1'b1);
      k = 0;
      while (cpu_run_o !== 1'b1 && k < 1000) begin
         @(posedge clk);
         k++;
      end
      k = fast ? FAST_LEN : SLOW_LEN;
      check("boot_len", 32'(rel_cnt >= k && rel_cnt <= k + 6), 32'h0000_0001);
   endtask

   // half period in core cycles of the next high phase
   task automatic meas(output int n);
      int k;
      k = 0;
      while (sys_clk_o === 1'b1 && k < 500) begin @(posedge clk); k++; end
      while (sys_clk_o !== 1'b1 && k < 1000) begin @(posedge clk); k++; end
      n = 0;
      while (sys_clk_o === 1'b1 && n < 500) begin @(posedge clk); n++; end
   endtask

   initial begin
      logic [7:0]  bt_mode [8] = '{8'h34, 8'h14, 8'h3C, 8'h1C, 8'h7C, 8'hE4, 8'hE6, 8'hE6};
      // slow is chosen with fast still on: the running source is never cut in the
      // write that leaves it
      logic [7:0]  sw_mode [7] = '{8'h34, 8'h14, 8'h3C, 8'h1C, 8'h7C, 8'hF4, 8'hB4};
      int          sw_half [7] = '{6, 12, 24, 48, 96, 40, 5};
      logic [1:0]  sw_src  [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
      logic [7:0]  tv;
      logic [31:0] d;
      int          n;
      logic        hi;
      // every boot option, random trim and boot length
      for (int o = 0; o < 8; o++) begin
         rnd = xs(rnd);
         tv = 8'(rnd[4:0]) + 8'h02;
         boot(o[2:0], rnd[8], tv, o == 0);
         rd(`SCC_ADR_CLK_MODE, 32'(bt_mode[o]));
         rd(`SCC_ADR_FAST_TRIM, (o < 6) ? 32'(tv) : 32'h0000_0010);
         check("wdt_en", 32'(wdt_en_o), 32'(o >= 6));
         check("pin_in", 32'(port_a_bit_five_oe_n), 32'h0000_0001);
         check("slow_en", 32'(slow_en_o), 32'h0000_0001);
         check("fast_en", 32'(fast_en_o), 32'(o < 5));
      end
      // trim write, lane refusal and an unmapped place
      wr(`SCC_ADR_FAST_TRIM, 8'h03, 1'b1);
      wr(`SCC_ADR_FAST_TRIM, 8'h55, 1'b0);
      rd(`SCC_ADR_FAST_TRIM, 32'h0000_0003);
      check("trim_out", 32'(fast_trim_o), 32'h0000_0003);
      rd(6'h14, 32'h0000_0000);
      // crystal enable and drive codes 1 to 3
      for (int v = 1; v < 4; v++) begin
         wr(`SCC_ADR_XTAL_CTRL, 8'h80 | 8'(v << 5), 1'b1);
         repeat (2) @(posedge clk);
         check("xtal_en", 32'(xtal_en_o), 32'h0000_0001);
         check("xtal_drv", 32'(xtal_drive_o), 32'(v));
      end
      // each source and every divider but 64, measured on the clock itself
      for (int m = 0; m < 7; m++) begin
         wr(`SCC_ADR_CLK_MODE, sw_mode[m], 1'b1);
         repeat (250) @(posedge clk);
         meas(n);
         check("half_per", 32'(n), 32'(sw_half[m]));
         check("fast_en", 32'(fast_en_o), 32'(sw_mode[m][4]));
         wb(1'b0, `SCC_ADR_STATUS, 8'h00, 1'b1, d);
         check("status", d & 32'h0000_000D, 32'({sw_src[m], 2'b01}));
      end
      // disabled source selected: the clock must stay low
      wr(`SCC_ADR_CLK_MODE, 8'h24, 1'b1);
      repeat (300) @(posedge clk);
      hi = 1'b0;
      repeat (200) begin
         @(posedge clk);
         if (sys_clk_o !== 1'b0) hi = 1'b1;
      end
      check("held_low", 32'(hi), 32'h0000_0000);
      wr(`SCC_ADR_XTAL_CTRL, 8'h00, 1'b1);
      repeat (2) @(posedge clk);
      check("xtal_off", 32'(xtal_en_o), 32'h0000_0000);
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule
